/* File: vims_ctrl.sv */
// Vectored interrupt, context switch and macro service sequencer.
// Summary of operation
// - branch through the source's vector table entry.
// - push PC and status word on entry.
// - return instruction pops PC and status word.
// - fixed two-byte vector per source, shared pairs.
// - context switch selects the source's register bank.
// - then branch to the vector held there.
// - context switch saves PC, status into bank.
// - macro moves one item between memory and register.
// - macro transfer leaves processor status untouched.
// - transmit request sends next buffered byte out.
// - after last byte, transmit event interrupts.
// - receive request stores received byte to memory.
// - after last byte, receive event interrupts.
// - compare request loads next pattern and interval.
// - compare match re-requests and latches the pattern.
// - last interval loaded raises compare interrupt.
// - second compare channel behaves like the first.
// - macro transfers run while the CPU halts.
// - equal priority served lowest default number first.
`timescale 1ns/10ps
module vims_ctrl
  import vims_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [SRC_N-1:0] srcReq,
  input wire logic [SRC_N-1:0] srcMask,
  input wire logic [SRC_N*PRIO_W-1:0] srcPrio,
  input wire logic [SRC_N-1:0] csEnable,
  input wire logic [SRC_N*BANK_W-1:0] csBank,
  input wire logic nmiPin,
  input wire logic watchdogOverflowSource,
  input wire logic softwareBreakInstr,
  input wire logic contextSwitchBreakInstr,
  input wire logic [BANK_W-1:0] csBreakBank,
  input wire logic operandError,
  input wire logic returnFromInterruptInstr,
  input wire logic cpuHalt,
  input wire logic [WORD_W-1:0] cpuPc,
  input wire logic [WORD_W-1:0] programStatusWord,
  input wire logic [WORD_W-1:0] bankVector,
  output logic stackWe,
  output logic stackRe,
  output logic [WORD_W-1:0] stackWData,
  input wire logic [WORD_W-1:0] stackRData,
  output logic branchValid,
  output logic branchViaTable,
  output logic [WORD_W-1:0] branchAddr,
  output logic [BANK_W-1:0] bankSelect,
  output logic bankSave,
  output logic [WORD_W-1:0] savedPc,
  output logic [WORD_W-1:0] savedPsw,
  output logic resumeValid,
  output logic [WORD_W-1:0] resumePc,
  output logic [WORD_W-1:0] resumePsw,
  input wire logic async0TxDoneRequest,
  input wire logic async0RxDoneRequest,
  input wire logic clockedSerial1DoneRequest,
  input wire logic clockedSerial2DoneRequest,
  input wire logic [BYTE_W-1:0] rxBufferRegister,
  input wire logic [MS_CH-1:0] msEnable,
  input wire logic [MS_CH-1:0] msLoad,
  input wire logic [CW-1:0] msLoadCount,
  input wire logic [WORD_W-1:0] msLoadPtr,
  output logic memRdEn,
  output logic [WORD_W-1:0] memRdAddr,
  input wire logic [WORD_W-1:0] memRdData,
  output logic wrValid,
  output logic wrToMem,
  output logic [WORD_W-1:0] wrAddr,
  output logic [WORD_W-1:0] wrData,
  input wire logic wrReady,
  input wire logic [WORD_W-1:0] timer1CountRegister,
  output logic [BYTE_W-1:0] rtOut0,
  output logic [BYTE_W-1:0] rtOut1
);
  vims_state_type state;
  logic nmiS1, nmiS2, nmiQ;
  logic [SRC_N-1:0] reqVec, pend, msTake, grantSrc;
  logic [EX_N-1:0] excIn, excPend, grantExc;
  logic [MS_CH-1:0] msPend, chReq, cmpHit;
  logic [CW-1:0] msCount [MS_CH];
  logic [WORD_W-1:0] msPtr [MS_CH];
  logic [WORD_W-1:0] cmpReg [2];
  logic [BYTE_W-1:0] patBuf [2];
  logic [1:0] cmpEqQ, cmpArmed;
  logic [1:0] msChan, gCh;
  logic msPhase, msDone, msIsRt, rtLoad, gMs, gExc, gSrc, selFound;
  logic [4:0] selIdx;
  logic [2:0] excIdx;
  logic [PRIO_W-1:0] selLvl;
  logic [WORD_W-1:0] msData, vecAddr;
  logic [SRC_N-1:0] rtLastSet;
  vims_fifo_if #(.W(FIFO_W)) wq ();

  // Maskable vector address; entries from the gap index on skip one slot.
  function automatic logic [15:0] vecOf(input logic [4:0] i);
    if (i >= 5'(VEC_GAP_IDX)) begin
      return VEC_GAP_BASE + {10'h000, i, 1'b0};
    end
    return VEC_BASE + {10'h000, i, 1'b0};
  endfunction

  // The NMI pin is synchronised before its edge is taken.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nmiS1 <= 1'b0;
      nmiS2 <= 1'b0;
      nmiQ <= 1'b0;
    end else begin
      nmiS1 <= nmiPin;
      nmiS2 <= nmiS1;
      nmiQ <= nmiS2;
    end
  end

  // Request sources; paired receive and clocked serial sources share an entry.
  always_comb begin
    reqVec = srcReq;
    reqVec[SRC_CMP0] = srcReq[SRC_CMP0] | cmpHit[CH_CMP0];
    reqVec[SRC_CMP1] = srcReq[SRC_CMP1] | cmpHit[CH_CMP1];
    reqVec[SRC_RX] = srcReq[SRC_RX] | async0RxDoneRequest | clockedSerial1DoneRequest;
    reqVec[SRC_TX] = srcReq[SRC_TX] | async0TxDoneRequest;
    reqVec[SRC_CSI2] = srcReq[SRC_CSI2] | clockedSerial2DoneRequest;
    excIn = '0;
    excIn[EX_RETURN_FROM_INTERRUPT_INSTR] = returnFromInterruptInstr;
    excIn[EX_BRK] = softwareBreakInstr;
    excIn[EX_CSBRK] = contextSwitchBreakInstr;
    excIn[EX_OPERR] = operandError;
    excIn[EX_NMI] = nmiS2 && !nmiQ;
    excIn[EX_WDT] = watchdogOverflowSource;
  end

  // A channel with transfers left takes its source's request as macro work.
  always_comb begin
    msTake = '0;
    rtLastSet = '0;
    for (int c = 0; c < MS_CH; c++) begin
      chReq[c] = reqVec[CH_SRC[c]] && msEnable[c] && (msCount[c] != '0);
      msTake[CH_SRC[c]] = chReq[c];
      // The final interval load raises the compare interrupt at once.
      rtLastSet[CH_SRC[c]] = msDone && (msChan == 2'(c)) && (c < 2) &&
        (msCount[c] == CW'(1));
    end
  end

  // Pending flags per maskable source; a new event wins over the grant clear.
  for (genvar i = 0; i < SRC_N; i++) begin : g_pend
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        pend[i] <= 1'b0;
      end else if ((reqVec[i] && !msTake[i]) || rtLastSet[i]) begin
        pend[i] <= 1'b1;
      end else if (grantSrc[i]) begin
        pend[i] <= 1'b0;
      end
    end
  end

  // Exception and macro pending flags, set winning over clear.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      excPend <= '0;
      msPend <= '0;
    end else begin
      excPend <= excIn | (excPend & ~grantExc);
      msPend <= chReq | (msPend & ~(gMs ? MS_CH'(1) << gCh : MS_CH'(0)));
    end
  end

  // Lowest programmed level value wins; ties go to the lowest default number.
  always_comb begin
    selFound = 1'b0;
    selIdx = '0;
    selLvl = '1;
    for (int i = 0; i < SRC_N; i++) begin
      if (pend[i] && !srcMask[i] && (!selFound || srcPrio[i*PRIO_W +: PRIO_W] < selLvl)) begin
        selFound = 1'b1;
        selIdx = 5'(i);
        selLvl = srcPrio[i*PRIO_W +: PRIO_W];
      end
    end
    excIdx = '0;
    for (int e = EX_N - 1; e >= 0; e--) begin
      if (excPend[e]) begin
        excIdx = 3'(e);
      end
    end
    gCh = '0;
    for (int c = MS_CH - 1; c >= 0; c--) begin
      if (msPend[c]) begin
        gCh = 2'(c);
      end
    end
  end

  // Macro work is granted even in halt; vectored work waits for the CPU.
  assign gMs = (state == ST_IDLE) && (msPend != '0);
  assign gExc = (state == ST_IDLE) && (msPend == '0) && !cpuHalt && (excPend != '0);
  assign gSrc = (state == ST_IDLE) && (msPend == '0) && !cpuHalt && (excPend == '0) && selFound;
  assign grantExc = gExc ? EX_N'(1) << excIdx : EX_N'(0);
  assign grantSrc = gSrc ? SRC_N'(1) << selIdx : SRC_N'(0);
  assign msIsRt = (msChan == 2'(CH_CMP0)) || (msChan == 2'(CH_CMP1));

  // Table address for the granted exception.
  always_comb begin
    unique case (excIdx)
      3'(EX_BRK): vecAddr = VEC_BREAK;
      3'(EX_OPERR): vecAddr = VEC_OPERR;
      3'(EX_NMI): vecAddr = VEC_NMI;
      3'(EX_WDT): vecAddr = VEC_WDT;
      default: vecAddr = RST_WORD;
    endcase
  end

  // Sequencer for entry, return and macro transfers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      branchAddr <= RST_WORD;
      branchViaTable <= 1'b0;
      bankSelect <= RST_BANK;
      savedPc <= RST_WORD;
      savedPsw <= RST_WORD;
      resumePc <= RST_WORD;
      resumePsw <= RST_WORD;
      msChan <= '0;
      msPhase <= 1'b0;
      msData <= RST_WORD;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (gMs) begin
            msChan <= gCh;
            msPhase <= 1'b0;
            state <= (gCh == 2'(CH_RX)) ? ST_MS_STORE : ST_MS_READ;
          end else if (gExc || gSrc) begin
            savedPc <= cpuPc;
            savedPsw <= programStatusWord;
            if (gExc && excIdx == 3'(EX_RETURN_FROM_INTERRUPT_INSTR)) begin
              state <= ST_POP1;
            end else if (gExc && excIdx == 3'(EX_CSBRK)) begin
              bankSelect <= csBreakBank;
              state <= ST_CTX;
            end else if (gSrc && csEnable[selIdx]) begin
              bankSelect <= csBank[selIdx*BANK_W +: BANK_W];
              state <= ST_CTX;
            end else begin
              branchAddr <= gExc ? vecAddr : vecOf(selIdx);
              branchViaTable <= 1'b1;
              state <= ST_PUSH_PC;
            end
          end
        end
        ST_PUSH_PC: state <= ST_PUSH_PSW;
        ST_PUSH_PSW: state <= ST_BRANCH;
        ST_CTX: begin
          branchAddr <= bankVector;
          branchViaTable <= 1'b0;
          state <= ST_BRANCH;
        end
        ST_BRANCH: state <= ST_IDLE;
        ST_POP1: state <= ST_POP2;
        ST_POP2: begin
          resumePsw <= stackRData;
          state <= ST_POP3;
        end
        ST_POP3: begin
          resumePc <= stackRData;
          state <= ST_RESUME;
        end
        ST_RESUME: state <= ST_IDLE;
        ST_MS_READ: state <= ST_MS_WAIT;
        ST_MS_WAIT: begin
          msData <= memRdData;
          if (msIsRt && !msPhase) begin
            msPhase <= 1'b1;
            state <= ST_MS_READ;
          end else begin
            state <= msIsRt ? ST_MS_DONE : ST_MS_STORE;
          end
        end
        ST_MS_STORE: begin
          if (wq.pushReady) begin
            state <= ST_MS_DONE;
          end
        end
        ST_MS_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Stack, bank and branch strobes decoded from the state.
  assign stackWe = (state == ST_PUSH_PC) || (state == ST_PUSH_PSW);
  assign stackWData = (state == ST_PUSH_PC) ? savedPc : savedPsw;
  assign stackRe = (state == ST_POP1) || (state == ST_POP2);
  assign bankSave = (state == ST_CTX);
  assign branchValid = (state == ST_BRANCH);
  assign resumeValid = (state == ST_RESUME);
  assign msDone = (state == ST_MS_DONE);

  // Macro memory reads; the interval word follows the pattern word.
  assign memRdEn = (state == ST_MS_READ);
  assign memRdAddr = msPtr[msChan] + {15'h0000, msPhase};
  assign rtLoad = (state == ST_MS_WAIT) && msIsRt && msPhase;

  // Stores go through the queue: received bytes to memory, others to transmit.
  assign wq.pushValid = (state == ST_MS_STORE);
  assign wq.pushData = (msChan == 2'(CH_RX)) ?
    {1'b1, msPtr[msChan], RST_BYTE, rxBufferRegister} :
    {1'b0, RST_WORD, RST_BYTE, msData[7:0]};
  assign wq.popReady = wrReady;
  assign wrValid = wq.popValid;
  assign {wrToMem, wrAddr, wrData} = wq.popData;

  vims_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) i_vims_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .q(wq)
  );

  // Per-channel transfer count and buffer pointer.
  for (genvar c = 0; c < MS_CH; c++) begin : g_chan
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        msCount[c] <= '0;
        msPtr[c] <= RST_WORD;
      end else if (msLoad[c]) begin
        msCount[c] <= msLoadCount;
        msPtr[c] <= msLoadPtr;
      end else if (msDone && msChan == 2'(c)) begin
        msCount[c] <= msCount[c] - 1'b1;
        msPtr[c] <= msPtr[c] + (c < 2 ? 16'h0002 : 16'h0001);
      end
    end
  end

  // Real-time outputs: match re-requests and moves the pattern to the latch.
  for (genvar k = 0; k < 2; k++) begin : g_rt
    assign cmpHit[k] = cmpArmed[k] && (timer1CountRegister == cmpReg[k]) && !cmpEqQ[k];
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cmpReg[k] <= RST_WORD;
        patBuf[k] <= RST_BYTE;
        cmpArmed[k] <= 1'b0;
        cmpEqQ[k] <= 1'b0;
      end else begin
        cmpEqQ[k] <= (timer1CountRegister == cmpReg[k]);
        if (rtLoad && msChan == 2'(k)) begin
          cmpReg[k] <= memRdData;
          patBuf[k] <= msData[7:0];
          cmpArmed[k] <= 1'b1;
        end
      end
    end
  end
  assign cmpHit[3:2] = 2'b00;

  // Output latches take the buffered pattern on each match.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rtOut0 <= RST_BYTE;
      rtOut1 <= RST_BYTE;
    end else begin
      if (cmpHit[0]) rtOut0 <= patBuf[0];
      if (cmpHit[1]) rtOut1 <= patBuf[1];
    end
  end

  // Checks on the sequencer.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_table_vector: assert property (gSrc && !csEnable[selIdx] |=> ##2 branchValid &&
    branchViaTable && branchAddr == vecOf($past(selIdx, 3))) else $error("bad vector");
  a_push_then_branch: assert property ($rose(stackWe) |-> stackWData == savedPc ##1
    stackWe && stackWData == savedPsw ##1 branchValid) else $error("bad push");
  a_return_pop: assert property (gExc && excIdx == 3'(EX_RETURN_FROM_INTERRUPT_INSTR) |=> stackRe[*2]
    ##2 resumeValid && resumePc == $past(stackRData)) else $error("bad return");
  a_bank_switch: assert property (bankSave |-> !stackWe ##1 branchValid &&
    !branchViaTable && branchAddr == $past(bankVector)) else $error("bad switch");
  a_macro_quiet: assert property (gMs |=> (!stackWe && !bankSave && !branchValid
    && !resumeValid) until msDone) else $error("macro touched status");
  a_macro_bound: assert property (gMs && gCh != 2'(CH_RX) |=> ##[3:4] msDone
    or ##[3:4] wq.pushValid) else $error("macro too slow");
  a_count_step: assert property (msDone && msChan == 2'(CH_TX) && !msLoad[CH_TX] |=>
    msCount[CH_TX] == $past(msCount[CH_TX]) - 1'b1) else $error("count not stepped");
  a_tx_last: assert property (async0TxDoneRequest && msCount[CH_TX] == '0 |=>
    pend[SRC_TX] || $past(grantSrc[SRC_TX])) else $error("no vectored tx");
  a_rt_latch: assert property (cmpHit[0] |=> rtOut0 == $past(patBuf[0]) &&
    $past(reqVec[SRC_CMP0])) else $error("pattern not latched");
  a_halt_macro: assert property (cpuHalt && state == ST_IDLE |=>
    state == ST_IDLE || state == ST_MS_READ || state == ST_MS_STORE) else $error("halt entry");
  c_vectored: cover property (gSrc ##3 branchValid);
  c_context: cover property (bankSave ##1 branchValid);
  c_rx_store: cover property (wq.pushValid && wq.pushReady && msChan == 2'(CH_RX));
  c_rt_match: cover property (cmpHit[1]);
endmodule

/* File: vims_pkg.sv */
// Shared constants and types of the vectored interrupt and macro service block.
package vims_pkg;
  // Source counts and field widths.
  localparam int SRC_N = 25;
  localparam int PRIO_W = 2;
  localparam int BANK_W = 3;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 8;
  localparam int MS_CH = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 1 + WORD_W + WORD_W;
  // Vector table addresses.
  localparam logic [15:0] VEC_BREAK = 16'h003E;
  localparam logic [15:0] VEC_OPERR = 16'h003C;
  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_WDT = 16'h0004;
  localparam logic [15:0] VEC_BASE = 16'h0006;
  localparam logic [15:0] VEC_GAP_BASE = 16'h0008;
  localparam int VEC_GAP_IDX = 21;
  // Maskable sources with extra request inputs (macro channels and SRC_CSI2), by default priority number.
  localparam int SRC_CMP0 = 6;
  localparam int SRC_CMP1 = 7;
  localparam int SRC_RX = 15;
  localparam int SRC_TX = 16;
  localparam int SRC_CSI2 = 19;
  // Macro channels, lowest index served first.
  localparam int CH_CMP0 = 0;
  localparam int CH_CMP1 = 1;
  localparam int CH_RX = 2;
  localparam int CH_TX = 3;
  localparam int CH_SRC [MS_CH] = '{SRC_CMP0, SRC_CMP1, SRC_RX, SRC_TX};
  // Exception flags, lowest index served first.
  localparam int EX_RETURN_FROM_INTERRUPT_INSTR = 0;
  localparam int EX_BRK = 1;
  localparam int EX_CSBRK = 2;
  localparam int EX_OPERR = 3;
  localparam int EX_NMI = 4;
  localparam int EX_WDT = 5;
  localparam int EX_N = 6;
  // Values after reset.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_BANK = 3'h0;
  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PUSH_PC = 4'h1,
    ST_PUSH_PSW = 4'h2,
    ST_CTX = 4'h3,
    ST_BRANCH = 4'h4,
    ST_POP1 = 4'h5,
    ST_POP2 = 4'h6,
    ST_POP3 = 4'h7,
    ST_RESUME = 4'h8,
    ST_MS_READ = 4'h9,
    ST_MS_WAIT = 4'hA,
    ST_MS_STORE = 4'hB,
    ST_MS_DONE = 4'hC
  } vims_state_type;
endpackage

/* File: vims_fifo_if.sv */
// Carrier for the store queue between the sequencer and its FIFO.
`timescale 1ns/10ps
interface vims_fifo_if #(parameter int W = 33);
  logic pushValid;
  logic pushReady;
  logic [W-1:0] pushData;
  logic popValid;
  logic popReady;
  logic [W-1:0] popData;
  modport store (input pushValid, input pushData, input popReady,
    output pushReady, output popValid, output popData);
  modport user (output pushValid, output pushData, output popReady,
    input pushReady, input popValid, input popData);
endinterface

/* File: vims_fifo.sv */
// Store queue FIFO with parameterised width and depth.
`timescale 1ns/10ps
module vims_fifo
  import vims_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  vims_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic full;
  logic empty;
  logic doPush;
  logic doPop;

  // Full when the pointers differ only in the wrap bit.
  assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty = (wrPtr == rdPtr);
  assign doPush = q.pushValid && !full;
  assign doPop = q.popReady && !empty;
  assign q.pushReady = !full;
  assign q.popValid = !empty;
  assign q.popData = mem[rdPtr[AW-1:0]];

  // Pointers advance on each accepted push and pop.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

  // Storage is written without reset; empty entries are never read out.
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr[AW-1:0]] <= q.pushData;
    end
  end
endmodule

/* File: vims_cpu_model.sv */
// Far-side model: program stack, data memory and a register sink that may stall.
`timescale 1ns/10ps
module vims_cpu_model
  import vims_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stackWe,
  input wire logic stackRe,
  input wire logic [WORD_W-1:0] stackWData,
  output logic [WORD_W-1:0] stackRData,
  input wire logic memRdEn,
  input wire logic [WORD_W-1:0] memRdAddr,
  output logic [WORD_W-1:0] memRdData,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [1:0] stallMode
);
  logic [WORD_W-1:0] stack[$];
  // Stack gives back the last word pushed; outside a pop its data line toggles every cycle.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack.delete();
      stackRData <= 16'h0000;
      memRdData <= 16'h0000;
      wrReady <= 1'b0;
    end else begin
      if (stackWe) begin
        stack.push_back(stackWData);
      end
      if (stackRe && stack.size() > 0) begin
        stackRData <= stack.pop_back();
      end else begin
        stackRData <= ~stackRData;
      end
      // Memory word is address-derived; every value is 16 bits wide, so within 0..FFFFH.
      memRdData <= memRdEn ? (memRdAddr ^ 16'h5A3C) : ~memRdData;
      // Mode 0 always ready, mode 1 random stalls, mode 2 stalled.
      wrReady <= (stallMode == 2'h0) || (stallMode == 2'h1 && $urandom_range(0, 1) == 1);
    end
  end
endmodule

/* File: vims_ctrl_tb.sv */
// Self-checking testbench of the interrupt and macro service sequencer.
`timescale 1ns/10ps
module vims_ctrl_tb;
  import vims_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [24:0] srcReq = '0;
  logic [24:0] srcMask = '0;
  logic [49:0] srcPrio = {25{2'h1}};
  logic [24:0] csEnable = '0;
  logic [74:0] csBank = {25{3'h5}};
  logic [8:0] pul = '0;
  logic nmiPin = 1'b0;
  logic cpuHalt = 1'b0;
  logic [2:0] csBreakBank = 3'h2;
  logic [15:0] cpuPc = 16'h0000;
  logic [15:0] programStatusWord = 16'h0000;
  logic [15:0] bankVector = 16'h0000;
  logic [7:0] rxBufferRegister = 8'h00;
  logic [3:0] msEnable = 4'h0;
  logic [3:0] msLoad = 4'h0;
  logic [7:0] msLoadCount = 8'h00;
  logic [15:0] msLoadPtr = 16'h0000;
  logic [15:0] timer1CountRegister = 16'h0000;
  logic [1:0] stallMode = 2'h0;
  logic stackWe, stackRe, branchValid, branchViaTable, bankSave, resumeValid;
  logic memRdEn, wrValid, wrToMem, wrReady;
  logic [15:0] stackWData, stackRData, branchAddr, savedPc, savedPsw, resumePc, resumePsw;
  logic [15:0] memRdAddr, memRdData, wrAddr, wrData;
  logic [2:0] bankSelect;
  logic [7:0] rtOut0, rtOut1;
  logic [15:0] rtPrev = 16'h0000;
  logic [15:0] rtExp = 16'h0000;
  logic [31:0] qBr[$], qStk[$], qRes[$], qWr[$], qRt[$], qBk[$];
  int numErrors = 0;
  int nTests = 0;

  vims_ctrl i_vims_ctrl (.core_clk, .rst, .srcReq, .srcMask, .srcPrio, .csEnable, .csBank,
    .nmiPin, .watchdogOverflowSource(pul[2]), .softwareBreakInstr(pul[0]),
    .contextSwitchBreakInstr(pul[3]), .csBreakBank, .operandError(pul[1]),
    .returnFromInterruptInstr(pul[4]), .cpuHalt, .cpuPc, .programStatusWord, .bankVector,
    .stackWe, .stackRe, .stackWData, .stackRData, .branchValid, .branchViaTable, .branchAddr,
    .bankSelect, .bankSave, .savedPc, .savedPsw, .resumeValid, .resumePc, .resumePsw,
    .async0TxDoneRequest(pul[5]), .async0RxDoneRequest(pul[6]),
    .clockedSerial1DoneRequest(pul[7]), .clockedSerial2DoneRequest(pul[8]), .rxBufferRegister,
    .msEnable, .msLoad, .msLoadCount, .msLoadPtr, .memRdEn, .memRdAddr, .memRdData, .wrValid,
    .wrToMem, .wrAddr, .wrData, .wrReady, .timer1CountRegister, .rtOut0, .rtOut1);

  vims_cpu_model i_vims_cpu_model (.core_clk, .rst, .stackWe, .stackRe, .stackWData,
    .stackRData, .memRdEn, .memRdAddr, .memRdData, .wrValid, .wrReady, .stallMode);

  // Clock of 10 ns period.
  always #5 core_clk = ~core_clk;

  // Prints the verdict and ends the run.
  task automatic results();
    if (numErrors == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compares a result against the oldest note of its queue; an empty queue is a mismatch.
  task automatic chk(ref logic [31:0] q[$], input logic [31:0] got);
    logic [31:0] e = 'x;
    nTests++;
    if (q.size() > 0) e = q.pop_front();
    if (q.size() == 0 && e === 'x || got !== e) begin
      numErrors++;
      $display("Error at %0t: expected %h got %h", $time, e, got);
    end
  endtask

  // Watches the outputs and checks each result as it appears.
  always @(posedge core_clk) begin
    if (!rst) begin
      if (branchValid) chk(qBr, {15'h0, branchViaTable, branchAddr});
      if (stackWe) chk(qStk, {16'h0, stackWData});
      if (bankSave) chk(qStk, {savedPsw, savedPc});
      if (bankSave) chk(qBk, {29'h0, bankSelect});
      if (resumeValid) chk(qRes, {resumePsw, resumePc});
      if (wrValid && wrReady) chk(qWr, {7'h0, wrToMem, wrAddr, wrData[7:0]});
      if ({rtOut1, rtOut0} !== rtPrev) chk(qRt, {16'h0, rtOut1, rtOut0});
      rtPrev = {rtOut1, rtOut0};
    end
  end

  function automatic logic [15:0] vec(input int i);
    return 16'h0006 + 16'(2 * i) + ((i >= 21) ? 16'h0002 : 16'h0000);
  endfunction

  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction

  // Codes below 25 pulse a maskable source, the rest a named request line.
  task automatic fire(input int c);
    @(negedge core_clk);
    if (c < 25) srcReq[c] = 1'b1;
    else pul[c - 25] = 1'b1;
    @(negedge core_clk);
    srcReq = '0;
    pul = '0;
  endtask

  task automatic newCtx();
    cpuPc = 16'($urandom);
    programStatusWord = 16'($urandom);
  endtask

  task automatic expVec(input logic [15:0] a);
    qStk.push_back({16'h0, cpuPc});
    qStk.push_back({16'h0, programStatusWord});
    qBr.push_back({15'h0, 1'b1, a});
  endtask

  task automatic load(input int ch, input int n, input logic [15:0] p);
    @(negedge core_clk);
    msLoad = 4'h1 << ch;
    msLoadCount = 8'(n);
    msLoadPtr = p;
    @(negedge core_clk);
    msLoad = 4'h0;
  endtask

  // Waits, within a bound, until every expected result has been seen.
  task automatic drain();
    int k;
    for (k = 0; k < 400 && qBr.size() + qStk.size() + qRes.size() + qWr.size() +
      qRt.size() + qBk.size() > 0; k++) @(negedge core_clk);
    if (k == 400) begin
      numErrors++;
      results();
    end else begin
      repeat (4) @(negedge core_clk);
    end
  endtask

  initial begin
    #900000;
    numErrors++;
    results();
  end

  initial begin
    int k;
    int src;
    int excCode[5] = '{25, 26, 27, 33, 32};
    logic [15:0] excVec[5] = '{16'h003E, 16'h003C, 16'h0004, 16'h002C, 16'h0024};
    src = $urandom(35);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    // Random maskable sources, each through its own table entry.
    for (k = 0; k < 8; k++) begin
      newCtx();
      src = $urandom_range(0, 24);
      expVec(vec(src));
      fire(src);
      drain();
    end
    for (k = 0; k < 5; k++) begin
      newCtx();
      expVec(excVec[k]);
      fire(excCode[k]);
      drain();
    end
    newCtx();
    expVec(16'h0002);
    nmiPin = 1'b1;
    drain();
    nmiPin = 1'b0;
    // Return pops the state pushed by the last entry.
    qRes.push_back({programStatusWord, cpuPc});
    fire(29);
    drain();
    // Two sources of equal level in one cycle, lower number first.
    newCtx();
    expVec(vec(3));
    expVec(vec(9));
    @(negedge core_clk);
    srcReq = 25'h0000208;
    @(negedge core_clk);
    srcReq = '0;
    drain();
    // A masked request waits and is served once unmasked.
    srcMask[5] = 1'b1;
    fire(5);
    repeat (30) @(negedge core_clk);
    expVec(vec(5));
    srcMask[5] = 1'b0;
    drain();
    // Context switch by a source and by the break instruction.
    csEnable[10] = 1'b1;
    for (k = 0; k < 2; k++) begin
      newCtx();
      bankVector = 16'($urandom);
      qBk.push_back(k ? 32'h2 : 32'h5);
      qStk.push_back({programStatusWord, cpuPc});
      qBr.push_back({16'h0, bankVector});
      fire(k ? 28 : 10);
      drain();
    end
    // Transmit macro while halted with random stalls; no stack traffic allowed.
    cpuHalt = 1'b1;
    stallMode = 2'h1;
    msEnable = 4'hF;
    load(3, 2, 16'h0040);
    for (k = 0; k < 2; k++) qWr.push_back({8'h00, 16'h0000, mb(16'h0040 + 16'(k))});
    for (k = 0; k < 3; k++) begin
      fire(30);
      repeat (12) @(negedge core_clk);
    end
    drain();
    expVec(16'h0026);
    cpuHalt = 1'b0;
    drain();
    // Receive burst into a stalled sink fills the store queue until it refuses.
    stallMode = 2'h2;
    rxBufferRegister = 8'($urandom);
    load(2, 17, 16'h0200);
    for (k = 0; k < 17; k++) begin
      qWr.push_back({7'h0, 1'b1, 16'h0200 + 16'(k), rxBufferRegister});
      fire(31);
      repeat (6) @(negedge core_clk);
    end
    stallMode = 2'h0;
    drain();
    expVec(16'h0024);
    fire(31);
    drain();
    // Both compare channels: last load interrupts, then the match latches the pattern.
    for (k = 0; k < 2; k++) begin
      load(k, 1, 16'h0100 + 16'(16 * k));
      newCtx();
      expVec(vec(6 + k));
      fire(6 + k);
      drain();
      srcMask[6 + k] = 1'b1;
      rtExp[8 * k +: 8] = mb(16'h0100 + 16'(16 * k));
      qRt.push_back({16'h0, rtExp});
      timer1CountRegister = (16'h0101 + 16'(16 * k)) ^ 16'h5A3C;
      drain();
      timer1CountRegister = 16'h0000;
    end
    results();
  end
endmodule
